// ---- src/sac_core.sv ----
// Serial transceiver control, status, shifters and APB register file.
// Assumes a single-word APB master and an asynchronous rxd pin.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps

// Functional notes
// - Length bit set gives nine-bit characters, clear gives eight; resets zero.
// - Standby ends on address mark when wake bit set, on idle line otherwise.
// - Quiet counting begins after stop bit when set, after start bit when clear.
// - With parity on, parity sits in the character's top bit and is checked.
// - Parity type set means odd, clear means even.
// - One start, one stop; frame is ten or eleven bits.
// - Four enables gate empty, complete, full and quiet flags onto two requests.
// - Setting transmit enable sends a preamble of ten or eleven ones.
// - Clearing transmit enable finishes the current character; re-set queues idle.
// - Clearing receive enable stops reception, keeps receiver flags.
// - Standby masks receiver requests until wake, which clears standby.
// - Break toggled sends one break then a one; held sends breaks back to back.
// - Received ninth bit is bit 8, or copy of bit 7 in eight-bit mode.
// - Transmit ninth bit loads on a ninth-bit register write, not with the buffer byte; reset leaves it alone.
// - Four error enables gate their flags onto the error request.
// - Transmit empty sets on transfer, clears by status read then data write.
// - Complete sets when empty and idle; clears once an item is queued.
// - Receive full sets on transfer, clears by status read then data read.
// - Quiet flag needs a full-flag since enable or last quiet clear.
// - Module disable forces empty and complete high, masks transmit requests.
module sac_core #(
  parameter int BIT_CYC = sac_pkg::SAC_BIT_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rxd,
  output logic txd,
  // Requests
  output logic tx_irq,
  output logic rx_irq,
  output logic err_irq
);
  import sac_pkg::*;

  localparam logic [15:0] BIT_END = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_END = 16'(BIT_CYC / 2 - 1);

  logic [7:0] fmt_r, fmt_nxt, ctl_r, ctl_nxt, sta_r, sta_nxt;
  logic [5:0] nin_r, nin_nxt;
  logic [7:0] snap_r, snap_nxt;
  logic arm_r, arm_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [7:0] txbuf_r, rdbuf_r;
  logic tx9_r, rx9_r;
  logic acc, wr, rd, hit, men, c9;
  logic [3:0] flen;
  logic tx_load, rx_xfer, rx_over, rx_wake, quiet_ev;
  logic [8:0] rx_word;
  logic rx_pe, rx_fe, rx_nf;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit = paddr inside {SAC_A_FMT, SAC_A_CTL, SAC_A_NIN, SAC_A_STA,
                             SAC_A_DAT};
  assign men = fmt_r[SAC_F_MEN];
  assign c9 = fmt_r[SAC_F_C9];
  assign flen = c9 ? 4'd11 : 4'd10;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = prdata_r;

  // Request outputs, levels from registered flags
  assign tx_irq = men && ((sta_r[SAC_S_TE] && ctl_r[SAC_C_TEIE]) ||
                  (sta_r[SAC_S_TC] && ctl_r[SAC_C_TX_DONE_IRQ_EN]));
  assign rx_irq = !ctl_r[SAC_C_STBY] &&
                  ((sta_r[SAC_S_RF] && ctl_r[SAC_C_RFIE]) ||
                   (sta_r[SAC_S_QT] && ctl_r[SAC_C_QIE]));
  assign err_irq = |(sta_r[3:0] & nin_r[3:0]);

  // ---------------- Transmitter ----------------
  sac_tx_t tx_st_r, tx_st_nxt;
  logic [10:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_cnt_r, tx_cnt_nxt;
  logic [15:0] tx_tmr_r, tx_tmr_nxt;
  logic pre_r, pre_nxt, te_prev_r, tail_r, tail_nxt, txd_r, txd_nxt;
  logic [10:0] dframe;
  logic tx_busy;

  assign tx_busy = tx_st_r == SAC_TX_SHIFT;
  assign txd = txd_r;

  // Data frame, parity replaces the top data bit
  always_comb begin
    logic [8:0] d;
    d = {tx9_r, txbuf_r};
    if (!c9) begin
      d[8] = 1'b1;
    end
    if (fmt_r[SAC_F_PEN]) begin
      if (c9) begin
        d[8] = ^txbuf_r ^ fmt_r[SAC_F_ODD];
      end else begin
        d[7] = ^txbuf_r[6:0] ^ fmt_r[SAC_F_ODD];
      end
    end
    dframe = {1'b1, d, 1'b0};
  end

  // Transmit sequencing; break outranks preamble, preamble outranks data
  always_comb begin
    logic ten;
    ten = ctl_r[SAC_C_TXEN] && men;
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_tmr_nxt = tx_tmr_r;
    tail_nxt = tail_r;
    txd_nxt = txd_r;
    tx_load = 1'b0;
    pre_nxt = pre_r || (ctl_r[SAC_C_TXEN] && !te_prev_r);
    if (tx_st_r == SAC_TX_SHIFT) begin
      tx_tmr_nxt = tx_tmr_r + 16'd1;
      if (tx_tmr_r == BIT_END) begin
        tx_tmr_nxt = 16'd0;
        tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
        tx_cnt_nxt = tx_cnt_r - 4'd1;
        if (tx_cnt_r == 4'd1) begin
          tx_st_nxt = SAC_TX_IDLE;
        end else begin
          txd_nxt = tx_sh_r[1];
        end
      end
    end else begin
      txd_nxt = 1'b1;
      tx_tmr_nxt = 16'd0;
      tx_cnt_nxt = flen;
      if (ten && ctl_r[SAC_C_BRK]) begin
        tx_sh_nxt = 11'h000;
        tail_nxt = 1'b1;
        pre_nxt = 1'b0;
        tx_st_nxt = SAC_TX_SHIFT;
      end else if (tail_r) begin
        tx_sh_nxt = 11'h7ff;
        tx_cnt_nxt = 4'd1;
        tail_nxt = 1'b0;
        tx_st_nxt = SAC_TX_SHIFT;
      end else if (ten && pre_r) begin
        tx_sh_nxt = 11'h7ff;
        pre_nxt = 1'b0;
        tx_st_nxt = SAC_TX_SHIFT;
      end else if (ten && !sta_r[SAC_S_TE]) begin
        tx_sh_nxt = dframe;
        tx_load = 1'b1;
        tx_st_nxt = SAC_TX_SHIFT;
      end
      if (tx_st_nxt == SAC_TX_SHIFT) begin
        txd_nxt = tx_sh_nxt[0];
      end
    end
    if (!men) begin
      pre_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= SAC_TX_IDLE;
      tx_sh_r <= 11'h7ff;
      tx_cnt_r <= 4'd0;
      tx_tmr_r <= 16'd0;
      pre_r <= 1'b0;
      te_prev_r <= 1'b0;
      tail_r <= 1'b0;
      txd_r <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_tmr_r <= tx_tmr_nxt;
      pre_r <= pre_nxt;
      te_prev_r <= ctl_r[SAC_C_TXEN];
      tail_r <= tail_nxt;
      txd_r <= txd_nxt;
    end
  end

  // ---------------- Receiver ----------------
  sac_rx_t rx_st_r, rx_st_nxt;
  logic rs1_r, rs2_r, rs3_r, line_r, line_nxt, lprev_r;
  logic [10:0] rx_sh_r, rx_sh_nxt;
  logic [3:0] rx_cnt_r, rx_cnt_nxt, q_cnt_r, q_cnt_nxt;
  logic [15:0] rx_tmr_r, rx_tmr_nxt;
  logic nacc_r, nacc_nxt;

  // Glitch filter: line moves only when the last two stages agree
  assign line_nxt = (rs2_r == rs3_r) ? rs3_r : line_r;

  always_comb begin
    logic [9:0] w;
    logic ren, smp;
    ren = ctl_r[SAC_C_RXEN] && men;
    rx_st_nxt = rx_st_r;
    rx_sh_nxt = rx_sh_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_tmr_nxt = rx_tmr_r + 16'd1;
    q_cnt_nxt = q_cnt_r;
    nacc_nxt = nacc_r;
    smp = rx_tmr_r == BIT_END;
    w = 10'h000;
    rx_word = 9'h000;
    rx_pe = 1'b0;
    rx_fe = 1'b0;
    rx_nf = 1'b0;
    rx_xfer = 1'b0;
    rx_over = 1'b0;
    rx_wake = 1'b0;
    quiet_ev = 1'b0;
    case (rx_st_r)
      SAC_RX_IDLE: begin
        if (!line_r) begin
          rx_st_nxt = SAC_RX_START;
          rx_tmr_nxt = 16'd0;
          q_cnt_nxt = 4'd0;
        end else if (smp) begin
          rx_tmr_nxt = 16'd0;
          if (q_cnt_r != flen) begin
            q_cnt_nxt = q_cnt_r + 4'd1;
            quiet_ev = q_cnt_nxt == flen;
          end
        end
      end
      SAC_RX_START: begin
        if (rx_tmr_r == HALF_END) begin
          rx_tmr_nxt = 16'd0;
          rx_cnt_nxt = 4'd0;
          nacc_nxt = 1'b0;
          rx_st_nxt = line_r ? SAC_RX_IDLE : SAC_RX_DATA;
        end
      end
      SAC_RX_DATA: begin
        if (smp) begin
          rx_tmr_nxt = 16'd0;
          rx_sh_nxt = {line_r, rx_sh_r[10:1]};
          rx_cnt_nxt = rx_cnt_r + 4'd1;
          nacc_nxt = nacc_r || (line_r != lprev_r);
          if (!fmt_r[SAC_F_QCS]) begin
            q_cnt_nxt = line_r ? q_cnt_r + 4'd1 : 4'd0;
          end
          if (rx_cnt_nxt == flen - 4'd1) begin
            rx_st_nxt = SAC_RX_IDLE;
            w = c9 ? rx_sh_nxt[10:1] : {1'b0, rx_sh_nxt[10:2]};
            rx_word = c9 ? w[8:0] : {w[7], w[7:0]};
            // Stop bit sits one place lower in eight-bit frames
            rx_fe = c9 ? !w[9] : !w[8];
            rx_pe = fmt_r[SAC_F_PEN] &&
                    ((c9 ? ^w[8:0] : ^w[7:0]) != fmt_r[SAC_F_ODD]);
            rx_nf = nacc_nxt;
            if (fmt_r[SAC_F_QCS]) begin
              q_cnt_nxt = 4'd0;
            end
            if (!ctl_r[SAC_C_STBY]) begin
              rx_xfer = 1'b1;
            end else if (fmt_r[SAC_F_WAKE] && rx_word[c9 ? 8 : 7]) begin
              rx_xfer = 1'b1;
              rx_wake = 1'b1;
            end
            if (rx_xfer && sta_r[SAC_S_RF]) begin
              rx_xfer = 1'b0;
              rx_over = 1'b1;
            end
          end
        end
      end
      default: rx_st_nxt = SAC_RX_IDLE;
    endcase
    if (quiet_ev && ctl_r[SAC_C_STBY] && !fmt_r[SAC_F_WAKE]) begin
      rx_wake = 1'b1;
      quiet_ev = 1'b0;
    end
    if (!ren) begin
      rx_st_nxt = SAC_RX_IDLE;
      q_cnt_nxt = 4'd0;
      rx_xfer = 1'b0;
      rx_over = 1'b0;
      rx_wake = 1'b0;
      quiet_ev = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= SAC_RX_IDLE;
      rs1_r <= 1'b1;
      rs2_r <= 1'b1;
      rs3_r <= 1'b1;
      line_r <= 1'b1;
      lprev_r <= 1'b1;
      rx_sh_r <= 11'h000;
      rx_cnt_r <= 4'd0;
      rx_tmr_r <= 16'd0;
      q_cnt_r <= 4'd0;
      nacc_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rs1_r <= rxd;
      rs2_r <= rs1_r;
      rs3_r <= rs2_r;
      line_r <= line_nxt;
      lprev_r <= line_r;
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_tmr_r <= rx_tmr_nxt;
      q_cnt_r <= q_cnt_nxt;
      nacc_r <= nacc_nxt;
    end
  end

  // ---------------- Register file ----------------
  // Flags other than complete clear through the two-step sequence, and noise, framing and parity also reload on each transfer; a set always wins
  always_comb begin
    logic dwr, drd, srd, qset;
    dwr = wr && paddr == SAC_A_DAT;
    drd = rd && paddr == SAC_A_DAT;
    srd = rd && paddr == SAC_A_STA;
    qset = quiet_ev && arm_r;
    fmt_nxt = fmt_r;
    ctl_nxt = ctl_r;
    nin_nxt = nin_r;
    sta_nxt = sta_r;
    snap_nxt = snap_r;
    arm_nxt = arm_r;
    prdata_nxt = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        SAC_A_FMT: prdata_nxt[7:0] = fmt_r;
        SAC_A_CTL: prdata_nxt[7:0] = ctl_r;
        SAC_A_NIN: prdata_nxt[7:0] = {rx9_r, tx9_r, nin_r};
        SAC_A_STA: prdata_nxt[7:0] = sta_r;
        SAC_A_DAT: prdata_nxt[7:0] = rdbuf_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (rx_wake) begin
      ctl_nxt[SAC_C_STBY] = 1'b0;
    end
    if (wr && paddr == SAC_A_FMT) begin
      fmt_nxt = pwdata[7:0];
    end
    if (wr && paddr == SAC_A_CTL) begin
      ctl_nxt = pwdata[7:0];
    end
    if (wr && paddr == SAC_A_NIN) begin
      nin_nxt = pwdata[5:0];
    end
    if (srd) begin
      snap_nxt = prdata_r[7:0];
    end else if (dwr || drd) begin
      snap_nxt = 8'h00;
    end
    if (dwr && snap_r[SAC_S_TE]) begin
      sta_nxt[SAC_S_TE] = 1'b0;
    end
    if (tx_load) begin
      sta_nxt[SAC_S_TE] = 1'b1;
    end
    if (drd) begin
      sta_nxt[5:0] = sta_r[5:0] & ~snap_r[5:0];
    end
    if (drd && snap_r[SAC_S_QT]) begin
      arm_nxt = 1'b0;
    end
    if (rx_xfer) begin
      sta_nxt[SAC_S_RF] = 1'b1;
      sta_nxt[SAC_S_FE] = rx_fe;
      sta_nxt[SAC_S_PE] = rx_pe;
      sta_nxt[SAC_S_NF] = rx_nf;
      arm_nxt = 1'b1;
    end
    if (rx_over) begin
      sta_nxt[SAC_S_OR] = 1'b1;
    end
    if (qset) begin
      sta_nxt[SAC_S_QT] = 1'b1;
      arm_nxt = 1'b0;
    end
    if (!ctl_r[SAC_C_RXEN]) begin
      arm_nxt = 1'b0;
    end
    sta_nxt[SAC_S_TC] = sta_nxt[SAC_S_TE] && !tx_busy && !pre_nxt &&
      !tail_r && !(ctl_r[SAC_C_BRK] && ctl_r[SAC_C_TXEN]);
    if (!men) begin
      sta_nxt[SAC_S_TE] = 1'b1;
      sta_nxt[SAC_S_TC] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_r <= SAC_CTL_RST;
      ctl_r <= SAC_CTL_RST;
      nin_r <= 6'h00;
      sta_r <= SAC_STA_RST;
      snap_r <= 8'h00;
      arm_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      fmt_r <= fmt_nxt;
      ctl_r <= ctl_nxt;
      nin_r <= nin_nxt;
      sta_r <= sta_nxt;
      snap_r <= snap_nxt;
      arm_r <= arm_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Data paths that reset leaves untouched
  always_ff @(posedge pclk) begin
    if (wr && paddr == SAC_A_DAT) begin
      txbuf_r <= pwdata[7:0];
    end
    if (wr && paddr == SAC_A_NIN) begin
      tx9_r <= pwdata[SAC_N_TX9];
    end
    if (rx_xfer) begin
      rdbuf_r <= rx_word[7:0];
      rx9_r <= rx_word[8];
    end
  end

  // ---------------- Checks ----------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_char_len: assert property (tx_load && c9 |=> tx_cnt_r == 4'd11)
    else $error("nine-bit frame not eleven bits");
  a_parity_gen: assert property (tx_load && fmt_r[SAC_F_PEN] && !c9 |=>
    tx_sh_r[8] == (^$past(txbuf_r[6:0]) ^ $past(fmt_r[SAC_F_ODD])))
    else $error("parity bit wrong");
  a_disable_force: assert property (!men |-> !tx_irq ##1
    (sta_r[SAC_S_TE] && sta_r[SAC_S_TC]))
    else $error("disable did not force flags");
  a_standby_mask: assert property (ctl_r[SAC_C_STBY] |-> !rx_irq)
    else $error("request during standby");
  a_tx_quiet_line: assert property (tx_st_r == SAC_TX_IDLE && !tail_r &&
    !ctl_r[SAC_C_TXEN] |=> txd)
    else $error("line not idle high");
  a_break_low: assert property (tx_st_r == SAC_TX_IDLE && men &&
    ctl_r[SAC_C_TXEN] && ctl_r[SAC_C_BRK] |=> !txd [*8])
    else $error("break not low");
  a_rx_full_set: assert property (rx_xfer |=> sta_r[SAC_S_RF])
    else $error("full flag missed");
  a_ninth_copy: assert property (rx_xfer && !c9 |=>
    rx9_r == rdbuf_r[7])
    else $error("ninth bit not copied");
  a_empty_set: assert property (tx_load |=> sta_r[SAC_S_TE])
    else $error("empty flag missed");
  a_quiet_armed: assert property ($rose(sta_r[SAC_S_QT]) |->
    $past(arm_r))
    else $error("quiet flag without full");
  a_done_clear: assert property (tx_busy && men |=> !sta_r[SAC_S_TC])
    else $error("complete high while shifting");
  a_rx_stop: assert property (!ctl_r[SAC_C_RXEN] |=>
    rx_st_r == SAC_RX_IDLE)
    else $error("receiver runs while off");

  c_tx_data: cover property (tx_load);
  c_rx_char: cover property (rx_xfer);
  c_quiet: cover property ($rose(sta_r[SAC_S_QT]));
  c_overrun: cover property (rx_over);
endmodule

// ---- src/sac_pkg.sv ----
// Package for the serial control and status block.
// Assumes an APB slave with 8-bit offsets and byte-wide registers.
package sac_pkg;
  // Register byte addresses
  localparam logic [7:0] SAC_A_FMT = 8'h00;
  localparam logic [7:0] SAC_A_CTL = 8'h04;
  localparam logic [7:0] SAC_A_NIN = 8'h08;
  localparam logic [7:0] SAC_A_STA = 8'h0c;
  localparam logic [7:0] SAC_A_DAT = 8'h10;
  // frame_format_control fields
  localparam int SAC_F_MEN = 6;
  localparam int SAC_F_C9 = 4;
  localparam int SAC_F_WAKE = 3;
  localparam int SAC_F_QCS = 2;
  localparam int SAC_F_PEN = 1;
  localparam int SAC_F_ODD = 0;
  // irq_and_enable_control fields
  localparam int SAC_C_TEIE = 7;
  localparam int SAC_C_TX_DONE_IRQ_EN = 6;
  localparam int SAC_C_RFIE = 5;
  localparam int SAC_C_QIE = 4;
  localparam int SAC_C_TXEN = 3;
  localparam int SAC_C_RXEN = 2;
  localparam int SAC_C_STBY = 1;
  localparam int SAC_C_BRK = 0;
  // ninth_bit_error_irq_control fields (bits 7 and 6 unreset)
  localparam int SAC_N_RX9 = 7;
  localparam int SAC_N_TX9 = 6;
  localparam int SAC_N_OVERRUN_IRQ_EN = 3;
  localparam int SAC_N_NOISE_IRQ_EN = 2;
  localparam int SAC_N_FRAMING_IRQ_EN = 1;
  localparam int SAC_N_PARITY_ERR_IRQ_EN = 0;
  // line_status_one fields
  localparam int SAC_S_TE = 7;
  localparam int SAC_S_TC = 6;
  localparam int SAC_S_RF = 5;
  localparam int SAC_S_QT = 4;
  localparam int SAC_S_OR = 3;
  localparam int SAC_S_NF = 2;
  localparam int SAC_S_FE = 1;
  localparam int SAC_S_PE = 0;
  // Reset values
  localparam logic [7:0] SAC_CTL_RST = 8'h00;
  localparam logic [7:0] SAC_STA_RST = 8'hc0;
  // Bit period in pclk cycles
  localparam int SAC_BIT_CYC = 16;
  typedef enum logic {SAC_TX_IDLE, SAC_TX_SHIFT} sac_tx_t;
  typedef enum logic [1:0] {SAC_RX_IDLE, SAC_RX_START, SAC_RX_DATA}
    sac_rx_t;
endpackage

// ---- verification/sac_peer.sv ----
// Remote serial peer facing the transceiver's txd and rxd lines.
// Assumes the bit period is BIT_CYC cycles of the shared pclk.
`timescale 1ns/1ps
module sac_peer #(
  parameter int BIT_CYC = 16
) (
  // Timing reference
  input wire logic pclk,
  // Serial lines seen from the far end
  input wire logic txd,
  output logic rxd
);
  // Line rests at mark level, as the pull-up would leave it
  initial rxd = 1'b1;

  // Start, nbits LSB first, then the chosen stop level
  task automatic send_frame(input int nbits, input logic [8:0] ch,
                            input logic stop);
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge pclk);
    for (int i = 0; i < nbits; i++) begin
      rxd <= ch[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    rxd <= stop;
    repeat (BIT_CYC) @(posedge pclk);
    rxd <= 1'b1;
  endtask

  // Mid-bit sampling of one frame; start time kept for preamble checks
  task automatic recv_frame(input int nbits, output logic [8:0] ch,
                            output logic stop, output time t_start);
    ch = 9'h000;
    @(negedge txd);
    t_start = $time;
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      ch[i] = txd;
    end
    repeat (BIT_CYC) @(posedge pclk);
    stop = txd;
  endtask
endmodule

// ---- verification/serial_async_control_status_test.sv ----
// Self-checking bench for the serial control and status block.
// Assumes sac_core with zero-wait APB and the sac_peer model on the line.
`timescale 1ns/1ps
module serial_async_control_status_test;
  import sac_pkg::*;
  localparam int BC = 16;
  // Modes as {nine_bit, parity_enable, parity_odd}
  localparam logic [2:0] MODES [6] = '{3'b000, 3'b100, 3'b010, 3'b011,
                                       3'b110, 3'b111};
  logic pclk, presetn, psel, penable, pwrite, rxd, txd;
  logic [7:0] paddr, q, mask;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, tx_irq, rx_irq, err_irq, e, stp;
  logic [8:0] v, w, got;
  logic [2:0] m;
  time t0, ts;
  int miscompares, tests_run;

  sac_core #(.BIT_CYC(BC)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .err_irq(err_irq));
  sac_peer #(.BIT_CYC(BC)) peer_u (.pclk(pclk), .txd(txd), .rxd(rxd));

  // 20 MHz clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  task automatic check(input logic [8:0] g, input logic [8:0] x);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // One APB transfer; waits on pready, takes data at that same edge
  task automatic apb(input logic [7:0] a, input logic wr, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Character on the wire: parity replaces the top bit when enabled
  function automatic logic [8:0] frame(input logic [2:0] md,
                                       input logic [8:0] d);
    logic [8:0] r;
    r = md[2] ? d : {1'b0, d[7:0]};
    if (md[1] && md[2]) r[8] = ^r[7:0] ^ md[0];
    else if (md[1]) r[7] = ^r[6:0] ^ md[0];
    return r;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected six thousand cycles
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    void'($urandom(32'h241b));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(SAC_A_STA, 1'b0, 8'h00);
    check(9'(q), 9'(SAC_STA_RST));
    apb(SAC_A_CTL, 1'b0, 8'h00);
    check(9'(q), 9'(SAC_CTL_RST));
    apb(SAC_A_FMT, 1'b0, 8'h00);
    check(9'(q), 9'h000);
    apb(SAC_A_NIN, 1'b0, 8'h00);
    check(9'(q[3:0]), 9'h000);
    apb(8'h14, 1'b0, 8'h00);
    check({e, q}, 9'h100);
    check({txd, tx_irq, rx_irq, err_irq}, 9'h008);
    $display("test reset done");
    // Empty request follows its enable, module disable masks it
    apb(SAC_A_FMT, 1'b1, 8'h40);
    apb(SAC_A_CTL, 1'b1, 8'h80);
    @(negedge pclk);
    check(9'(tx_irq), 9'h001);
    apb(SAC_A_FMT, 1'b1, 8'h00);
    @(negedge pclk);
    check(9'(tx_irq), 9'h000);
    apb(SAC_A_FMT, 1'b1, 8'h40);
    apb(SAC_A_CTL, 1'b1, 8'h2c);
    t0 = $time;
    $display("test request gating done");
    // Every character format, one byte each way
    foreach (MODES[k]) begin
      m = MODES[k];
      apb(SAC_A_FMT, 1'b1, {3'b010, m[2], 1'b0, m[0], m[1:0]});
      v = 9'($urandom_range(0, 511));
      apb(SAC_A_NIN, 1'b1, {1'b0, v[8], 6'h0f});
      apb(SAC_A_STA, 1'b0, 8'h00);
      fork
        peer_u.recv_frame(m[2] ? 9 : 8, got, stp, ts);
        apb(SAC_A_DAT, 1'b1, v[7:0]);
      join
      check(got, frame(m, v));
      check(9'(stp), 9'h001);
      if (k == 0) check(9'(ts - t0 >= 10 * BC * 50), 9'h001);
      w = frame(m, 9'($urandom_range(0, 511)));
      peer_u.send_frame(m[2] ? 9 : 8, w, 1'b1);
      repeat (12 * BC) @(posedge pclk);
      check(9'(rx_irq), 9'h001);
      apb(SAC_A_STA, 1'b0, 8'h00);
      check(9'(q), 9'h0f0);
      mask = (m[1] && !m[2]) ? 8'h7f : 8'hff;
      apb(SAC_A_DAT, 1'b0, 8'h00);
      check(9'(q & mask), 9'(w[7:0] & mask));
      apb(SAC_A_NIN, 1'b0, 8'h00);
      check(9'(q[7]), 9'(m[2] ? w[8] : w[7]));
      repeat (12 * BC) @(posedge pclk);
      apb(SAC_A_STA, 1'b0, 8'h00);
      check(9'(q), 9'h0c0);
    end
    $display("test formats done");
    // Bad parity and a zero stop bit, flags kept with receiver off
    apb(SAC_A_FMT, 1'b1, 8'h42);
    peer_u.send_frame(8, frame(3'b010, 9'h005) ^ 9'h080, 1'b0);
    repeat (2 * BC) @(posedge pclk);
    check(9'(err_irq), 9'h001);
    apb(SAC_A_CTL, 1'b1, 8'h28);
    apb(SAC_A_STA, 1'b0, 8'h00);
    check(9'(q & 8'h23), 9'h023);
    apb(SAC_A_DAT, 1'b0, 8'h00);
    @(negedge pclk);
    check(9'(err_irq), 9'h000);
    $display("test errors done");
    // Break toggled long after the line went idle
    fork
      peer_u.recv_frame(8, got, stp, ts);
      begin
        apb(SAC_A_CTL, 1'b1, 8'h29);
        apb(SAC_A_CTL, 1'b1, 8'h28);
      end
    join
    check({got[7:0], stp}, 9'h000);
    repeat (BC) @(posedge pclk);
    check(9'(txd), 9'h001);
    $display("test break done");
    // Standby with address-mark wake
    apb(SAC_A_FMT, 1'b1, 8'h48);
    apb(SAC_A_CTL, 1'b1, 8'h2e);
    peer_u.send_frame(8, 9'h012, 1'b1);
    repeat (2 * BC) @(posedge pclk);
    check(9'(rx_irq), 9'h000);
    apb(SAC_A_STA, 1'b0, 8'h00);
    check(9'(q[5]), 9'h000);
    peer_u.send_frame(8, 9'h0a5, 1'b1);
    repeat (2 * BC) @(posedge pclk);
    apb(SAC_A_CTL, 1'b0, 8'h00);
    check(9'(q[1]), 9'h000);
    check(9'(rx_irq), 9'h001);
    $display("test standby done");
    // Idle-line wake; the line must rest first or standby ends at once
    repeat (12 * BC) @(posedge pclk);
    apb(SAC_A_STA, 1'b0, 8'h00);
    apb(SAC_A_DAT, 1'b0, 8'h00);
    apb(SAC_A_FMT, 1'b1, 8'h40);
    apb(SAC_A_CTL, 1'b1, 8'h2e);
    peer_u.send_frame(8, 9'h03c, 1'b1);
    repeat (12 * BC) @(posedge pclk);
    apb(SAC_A_CTL, 1'b0, 8'h00);
    check(9'(q[1]), 9'h000);
    apb(SAC_A_STA, 1'b0, 8'h00);
    check(9'(q[5:4]), 9'h000);
    $display("test idle wake done");
    tally_and_finish();
  end
endmodule
